// ---- hdl/sogs_defs.vh ----
// Constants for the servo overshoot and gain switch block.
// Assumes a single 200 MHz clock and an AXI4-Lite register slave.
// Contract
// - Compensate when |error| within enable level
// - Once-only bit: one compensation per move
// - Bit 0 enables position gain switching
// - Double gain at or below limit speed
// - Bit 5 keeps feed-forward undoubled
// - Bit 1 scales threshold speeds by ten
// - Integrator updates only at low speed
// - Master bit enables overshoot compensation
// - Zero count means plain compensation
`ifndef SOGS_DEFS_VH
`define SOGS_DEFS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define SOGS_OFS_OVS_LEVEL 8'h00
`define SOGS_OFS_OVS_ONCE 8'h04
`define SOGS_OFS_GSW_CTRL 8'h08
`define SOGS_OFS_GSW_LIMIT 8'h0c
`define SOGS_OFS_FF_CTRL 8'h10
`define SOGS_OFS_SPD_UNIT 8'h14
`define SOGS_OFS_OVS_CTRL 8'h18
`define SOGS_OFS_LSI_LIMIT 8'h1c
`define SOGS_OFS_STATUS 8'h20
// ****************************************
// Field positions
// ****************************************
`define SOGS_BIT_ONCE 3
`define SOGS_BIT_GSW_EN 0
`define SOGS_BIT_FF_NODBL 5
`define SOGS_BIT_UNIT_X10 1
`define SOGS_BIT_OVS_EN 0
`define SOGS_BIT_LSI_EN 1
`define SOGS_CNT_LSB 8
`define SOGS_CNT_MSB 15
// ****************************************
// Reset values and codes
// ****************************************
`define SOGS_RST_LEVEL 15'h0000
`define SOGS_RST_LIMIT 15'h0000
`define SOGS_RST_BYTE 8'h00
`define SOGS_RESP_OKAY 2'b00
`define SOGS_RESP_SLVERR 2'b10
`endif

// ---- hdl/sogs_core.v ----
// Per-sample decisions of the overshoot and gain switch logic.
// Assumes error and speed are sampled on the servo sample strobe.
`default_nettype none
module sogs_core
(
   input wire aclk,
   input wire aresetn,
   input wire sample_en,
   input wire move_active,
   input wire [31:0] pos_error,
   input wire [31:0] speed,
   input wire [14:0] ovs_level,
   input wire ovs_en,
   input wire once_after_move_comp,
   input wire [7:0] incomplete_integration_count,
   input wire gain_switch_en,
   input wire [14:0] gsw_limit,
   input wire ff_no_double,
   input wire speed_unit_x10,
   input wire lsi_en,
   input wire [14:0] lsi_limit,
   output reg comp_apply_q,
   output reg hold_apply_q,
   output reg gain_double_q,
   output reg ff_double_q,
   output reg integ_en_q
);
   wire [31:0] abs_err;
   wire [35:0] gsw_thr;
   wire [35:0] lsi_thr;
   wire [31:0] abs_spd;
   wire in_band;
   wire comp_d;
   reg done_q;
   reg [7:0] hold_cnt_q;
   assign abs_err = pos_error[31] ? (~pos_error + 32'h00000001) : pos_error;
   assign abs_spd = speed[31] ? (~speed + 32'h00000001) : speed;
   // Unit x10 scales thresholds, not the measured speed
   assign gsw_thr = speed_unit_x10 ? ({21'h000000, gsw_limit} * 36'h00000000a)
      : {21'h000000, gsw_limit};
   assign lsi_thr = speed_unit_x10 ? ({21'h000000, lsi_limit} * 36'h00000000a)
      : {21'h000000, lsi_limit};
   // Level zero collapses to exact zero error
   assign in_band = abs_err <= {17'h00000, ovs_level};
   assign comp_d = ovs_en && in_band && !move_active
      && !(once_after_move_comp && done_q);
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         comp_apply_q <= 1'b0;
         hold_apply_q <= 1'b0;
         gain_double_q <= 1'b0;
         ff_double_q <= 1'b0;
         integ_en_q <= 1'b1;
         done_q <= 1'b0;
         hold_cnt_q <= 8'h00;
      end
      else if (sample_en)
      begin
         if (move_active)
            done_q <= 1'b0;
         else if (comp_d && once_after_move_comp)
            done_q <= 1'b1;
         // Latched on the applying sample itself, so a second pass cannot slip in
         comp_apply_q <= comp_d;
         // Count zero gives no holding phase; less-than survives a lowered count
         if (!(ovs_en && in_band) || move_active)
            hold_cnt_q <= 8'h00;
         else if (hold_cnt_q < incomplete_integration_count)
            hold_cnt_q <= hold_cnt_q + 8'h01;
         hold_apply_q <= ovs_en && in_band
            && (hold_cnt_q < incomplete_integration_count);
         gain_double_q <= gain_switch_en && ({4'h0, abs_spd} <= gsw_thr);
         ff_double_q <= gain_switch_en && ({4'h0, abs_spd} <= gsw_thr)
            && !ff_no_double;
         integ_en_q <= !lsi_en || ({4'h0, abs_spd} <= lsi_thr);
      end
   end
endmodule // sogs_core
`default_nettype wire

// ---- hdl/sogs_top.v ----
// Register file and top of the servo overshoot and gain switch block.
// Assumes an AXI4-Lite master on aclk and a servo sample strobe.
`include "sogs_defs.vh"
`default_nettype none
module sogs_top
(
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire sample_en,
   input wire move_active,
   input wire [31:0] pos_error,
   input wire [31:0] speed,
   output wire comp_apply_q,
   output wire hold_apply_q,
   output wire gain_double_q,
   output wire ff_double_q,
   output wire integ_en_q
);
   // ****************************************
   // Registers
   // ****************************************
   reg [14:0] level_q;
   reg [7:0] once_q;
   reg [7:0] gsw_q;
   reg [14:0] limit_q;
   reg [7:0] ff_q;
   reg [7:0] unit_q;
   reg [15:0] ovs_ctrl_q;
   reg [14:0] lsi_limit_q;
   reg [7:0] aw_q;
   reg [31:0] wd_q;
   reg [3:0] ws_q;
   reg aw_have_q;
   reg w_have_q;
   wire [7:0] aw_addr;
   wire [31:0] wdat;
   wire [3:0] wstb;
   wire aw_ok;
   wire w_ok;
   wire do_write;
   reg [31:0] rd_d;
   reg rd_err_d;
   reg wr_err_d;
   assign aw_addr = aw_have_q ? aw_q : s_axi_awaddr;
   assign wdat = w_have_q ? wd_q : s_axi_wdata;
   assign wstb = w_have_q ? ws_q : s_axi_wstrb;
   assign aw_ok = aw_have_q || (s_axi_awvalid && s_axi_awready);
   assign w_ok = w_have_q || (s_axi_wvalid && s_axi_wready);
   assign do_write = aw_ok && w_ok && !s_axi_bvalid;
   always @*
   begin
      wr_err_d = 1'b0;
      case (aw_addr)
         `SOGS_OFS_OVS_LEVEL, `SOGS_OFS_OVS_ONCE, `SOGS_OFS_GSW_CTRL,
         `SOGS_OFS_GSW_LIMIT, `SOGS_OFS_FF_CTRL, `SOGS_OFS_SPD_UNIT,
         `SOGS_OFS_OVS_CTRL, `SOGS_OFS_LSI_LIMIT, `SOGS_OFS_STATUS:
            wr_err_d = 1'b0;
         default:
            wr_err_d = 1'b1;
      endcase
   end
   // ****************************************
   // Write channel
   // ****************************************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SOGS_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 8'h00;
         wd_q <= 32'h00000000;
         ws_q <= 4'h0;
         level_q <= `SOGS_RST_LEVEL;
         once_q <= `SOGS_RST_BYTE;
         gsw_q <= `SOGS_RST_BYTE;
         limit_q <= `SOGS_RST_LIMIT;
         ff_q <= `SOGS_RST_BYTE;
         unit_q <= `SOGS_RST_BYTE;
         ovs_ctrl_q <= 16'h0000;
         lsi_limit_q <= `SOGS_RST_LIMIT;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (do_write)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err_d ? `SOGS_RESP_SLVERR : `SOGS_RESP_OKAY;
            case (aw_addr)
               `SOGS_OFS_OVS_LEVEL:
               begin
                  if (wstb[0])
                     level_q[7:0] <= wdat[7:0];
                  if (wstb[1])
                     level_q[14:8] <= wdat[14:8];
               end
               `SOGS_OFS_OVS_ONCE:
                  if (wstb[0])
                     once_q <= wdat[7:0];
               `SOGS_OFS_GSW_CTRL:
                  if (wstb[0])
                     gsw_q <= wdat[7:0];
               `SOGS_OFS_GSW_LIMIT:
               begin
                  if (wstb[0])
                     limit_q[7:0] <= wdat[7:0];
                  if (wstb[1])
                     limit_q[14:8] <= wdat[14:8];
               end
               `SOGS_OFS_FF_CTRL:
                  if (wstb[0])
                     ff_q <= wdat[7:0];
               `SOGS_OFS_SPD_UNIT:
                  if (wstb[0])
                     unit_q <= wdat[7:0];
               `SOGS_OFS_OVS_CTRL:
               begin
                  if (wstb[0])
                     ovs_ctrl_q[7:0] <= wdat[7:0];
                  if (wstb[1])
                     ovs_ctrl_q[15:8] <= wdat[15:8];
               end
               `SOGS_OFS_LSI_LIMIT:
               begin
                  if (wstb[0])
                     lsi_limit_q[7:0] <= wdat[7:0];
                  if (wstb[1])
                     lsi_limit_q[14:8] <= wdat[14:8];
               end
               default:
                  aw_q <= aw_q;
            endcase
         end
         else
         begin
            // Hold whichever half arrived first
            if (s_axi_awvalid && s_axi_awready)
            begin
               aw_have_q <= 1'b1;
               aw_q <= s_axi_awaddr;
               s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
               w_have_q <= 1'b1;
               wd_q <= s_axi_wdata;
               ws_q <= s_axi_wstrb;
               s_axi_wready <= 1'b0;
            end
         end
      end
   end
   // ****************************************
   // Read channel
   // ****************************************
   always @*
   begin
      rd_d = 32'h00000000;
      rd_err_d = 1'b0;
      case (s_axi_araddr)
         `SOGS_OFS_OVS_LEVEL:
            rd_d = {17'h00000, level_q};
         `SOGS_OFS_OVS_ONCE:
            rd_d = {24'h000000, once_q};
         `SOGS_OFS_GSW_CTRL:
            rd_d = {24'h000000, gsw_q};
         `SOGS_OFS_GSW_LIMIT:
            rd_d = {17'h00000, limit_q};
         `SOGS_OFS_FF_CTRL:
            rd_d = {24'h000000, ff_q};
         `SOGS_OFS_SPD_UNIT:
            rd_d = {24'h000000, unit_q};
         `SOGS_OFS_OVS_CTRL:
            rd_d = {16'h0000, ovs_ctrl_q};
         `SOGS_OFS_LSI_LIMIT:
            rd_d = {17'h00000, lsi_limit_q};
         `SOGS_OFS_STATUS:
            rd_d = {27'h0000000, integ_en_q, ff_double_q, gain_double_q,
               hold_apply_q, comp_apply_q};
         default:
            rd_err_d = 1'b1;
      endcase
   end
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SOGS_RESP_OKAY;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_d;
         s_axi_rresp <= rd_err_d ? `SOGS_RESP_SLVERR : `SOGS_RESP_OKAY;
      end
   end
   // ****************************************
   // Servo decisions
   // ****************************************
   sogs_core u_core
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_en(sample_en),
      .move_active(move_active),
      .pos_error(pos_error),
      .speed(speed),
      .ovs_level(level_q),
      .ovs_en(ovs_ctrl_q[`SOGS_BIT_OVS_EN]),
      .once_after_move_comp(once_q[`SOGS_BIT_ONCE]),
      .incomplete_integration_count(ovs_ctrl_q[`SOGS_CNT_MSB:`SOGS_CNT_LSB]),
      .gain_switch_en(gsw_q[`SOGS_BIT_GSW_EN]),
      .gsw_limit(limit_q),
      .ff_no_double(ff_q[`SOGS_BIT_FF_NODBL]),
      .speed_unit_x10(unit_q[`SOGS_BIT_UNIT_X10]),
      .lsi_en(ovs_ctrl_q[`SOGS_BIT_LSI_EN]),
      .lsi_limit(lsi_limit_q),
      .comp_apply_q(comp_apply_q),
      .hold_apply_q(hold_apply_q),
      .gain_double_q(gain_double_q),
      .ff_double_q(ff_double_q),
      .integ_en_q(integ_en_q)
   );
endmodule // sogs_top
`default_nettype wire

// ---- tb/sogs_properties.sv ----
// Port checker for the servo overshoot and gain switch top.
// Assumes the master offers write address and data together.
`default_nettype none
module sogs_properties
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_en,
   input wire logic move_active,
   input wire logic comp_apply_q,
   input wire logic gain_double_q,
   input wire logic ff_double_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Properties
   // ****************************************
   logic gsw_en_q;
   logic wr_hs;
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // Shadow enable; full-strobe writes only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gsw_en_q <= 1'b0;
      else if (wr_hs && s_axi_awaddr == 8'h08)
         gsw_en_q <= s_axi_wdata[0];
   end
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_FF_NEEDS_GAIN: assert property (ff_double_q |-> gain_double_q)
      else $error("ff doubled alone");
   AST_GAIN_OFF: assert property (sample_en && !gsw_en_q |=> !gain_double_q)
      else $error("gain doubled while disabled");
   AST_NO_COMP_MOVING: assert property (sample_en && move_active |=> !comp_apply_q)
      else $error("compensation during move");
   AST_HOLD_BETWEEN: assert property (!sample_en |=>
      $stable({comp_apply_q, gain_double_q, ff_double_q})) else $error("decision off strobe");
   AST_B_ANSWER: assert property (wr_hs |=> s_axi_bvalid)
      else $error("no write response");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped");
endmodule // sogs_properties
bind sogs_top sogs_properties u_sogs_properties (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .sample_en, .move_active, .comp_apply_q, .gain_double_q, .ff_double_q);
`default_nettype wire

// ---- tb/sogs_motor_model.sv ----
// Motor and detector model giving error and speed samples.
// Assumes the bench asks for one sample at a time with req.
`default_nettype none
module sogs_motor_model
(
   input wire logic aclk,
   input wire logic req,
   input wire logic mv,
   input wire logic [31:0] err,
   input wire logic [31:0] spd,
   output logic sample_en,
   output logic move_active,
   output logic [31:0] pos_error,
   output logic [31:0] speed
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Detector
   // ****************************************
   // Inverted off strobe, so late sampling shows up
   always_ff @(posedge aclk)
   begin
      sample_en <= req;
      move_active <= mv;
      pos_error <= req ? err : ~err;
      speed <= req ? spd : ~spd;
   end
endmodule // sogs_motor_model
`default_nettype wire

// ---- tb/tb_servo_overshoot_gain_switch.sv ----
// Self-checking bench of the overshoot and gain switch block.
// Assumes the motor model and checker are compiled first.
`default_nettype none
module tb_servo_overshoot_gain_switch;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Bench
   // ****************************************
   logic aclk = 1'b0, aresetn = 1'b0, req = 1'b0, mv = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, err = 32'h0, spd = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, pos_error, speed;
   logic sample_en, move_active, comp_apply_q, hold_apply_q, gain_double_q, ff_double_q;
   logic integ_en_q;
   logic [4:0] dec;
   int mismatches = 0, n_checks = 0;
   assign dec = {integ_en_q, ff_double_q, gain_double_q, hold_apply_q, comp_apply_q};
   sogs_top u_sogs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_en, .move_active, .pos_error,
      .speed, .comp_apply_q, .hold_apply_q, .gain_double_q, .ff_double_q, .integ_en_q);
   sogs_motor_model u_sogs_motor_model (.aclk, .req, .mv, .err, .spd, .sample_en,
      .move_active, .pos_error, .speed);
   initial
      forever #2.5 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Ready for the answer from the start; a missing answer counts as a mismatch
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ok;
      ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (64)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            ok = 1'b1;
            break;
         end
      end
      s_axi_bready <= 1'b0;
      chk({31'h0, ok}, 32'h1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ok;
      ok = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (64)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            ok = 1'b1;
            break;
         end
      end
      s_axi_rready <= 1'b0;
      chk({31'h0, ok}, 32'h1);
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // One strobed sample, then all five decisions
   task automatic samp(input logic [31:0] e, input logic [31:0] s, input logic [4:0] ex);
      @(posedge aclk);
      req <= 1'b1;
      err <= e;
      spd <= s;
      @(posedge aclk);
      req <= 1'b0;
      @(posedge aclk);
      #1;
      chk({27'h0, dec}, {27'h0, ex});
   endtask
   task automatic move(input logic m);
      @(posedge aclk);
      mv <= m;
   endtask
   task automatic t_regs;
      logic [31:0] m [8] = '{32'h7fff, 32'hff, 32'hff, 32'h7fff, 32'hff, 32'hff, 32'h3,
         32'h7fff};
      for (int i = 0; i < 8; i++)
      begin
         axr(8'(i * 4), 32'h0, 2'h0);
         axw(8'(i * 4), (i == 6) ? 32'h3 : 32'hffffffff, 2'h0);
         axr(8'(i * 4), m[i], 2'h0);
         axw(8'(i * 4), 32'h0, 2'h0);
      end
      axr(8'h20, 32'h10, 2'h0);
      axr(8'h24, 32'h0, 2'h2);
      axw(8'h24, 32'hffffffff, 2'h2);
   endtask
   task automatic t_comp;
      axw(8'h00, 32'ha, 2'h0);
      samp(32'h0, 32'h0, 5'h10);
      axw(8'h18, 32'h1, 2'h0);
      samp(32'ha, 32'h0, 5'h11);
      samp(32'hfffffff6, 32'h0, 5'h11);
      axr(8'h20, 32'h11, 2'h0);
      samp(32'hb, 32'h0, 5'h10);
      axw(8'h00, 32'h0, 2'h0);
      samp(32'h0, 32'h0, 5'h11);
      samp(32'hffffffff, 32'h0, 5'h10);
      axw(8'h18, 32'h201, 2'h0);
      samp(32'h0, 32'h0, 5'h13);
      samp(32'h0, 32'h0, 5'h13);
      samp(32'h0, 32'h0, 5'h11);
      samp(32'h1, 32'h0, 5'h10);
      samp(32'h0, 32'h0, 5'h13);
      axw(8'h18, 32'h1, 2'h0);
   endtask
   task automatic t_once;
      axw(8'h04, 32'h8, 2'h0);
      for (int k = 0; k < 2; k++)
      begin
         move(1'b1);
         samp(32'h0, 32'h0, 5'h10);
         move(1'b0);
         samp(32'h0, 32'h0, 5'h11);
         samp(32'h0, 32'h0, 5'h10);
      end
      axw(8'h04, 32'h0, 2'h0);
   endtask
   task automatic t_gain;
      axw(8'h0c, 32'h5dc, 2'h0);
      samp(32'h5, 32'h5dc, 5'h10);
      axw(8'h08, 32'h1, 2'h0);
      samp(32'h5, 32'h5dc, 5'h1c);
      samp(32'h5, 32'h5dd, 5'h10);
      samp(32'h5, 32'hfffffa24, 5'h1c);
      axw(8'h10, 32'h20, 2'h0);
      samp(32'h5, 32'h5dc, 5'h14);
      axw(8'h14, 32'h2, 2'h0);
      samp(32'h5, 32'h3a98, 5'h14);
      samp(32'h5, 32'h3a99, 5'h10);
   endtask
   task automatic t_lsi;
      axw(8'h1c, 32'h64, 2'h0);
      axw(8'h18, 32'h3, 2'h0);
      samp(32'h5, 32'h3e8, 5'h14);
      samp(32'h5, 32'h3e9, 5'h04);
      axw(8'h14, 32'h0, 2'h0);
      samp(32'h5, 32'h64, 5'h14);
      samp(32'h5, 32'h65, 5'h04);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #50000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk({27'h0, dec}, 32'h10);
      t_regs();
      t_comp();
      t_once();
      t_gain();
      t_lsi();
      complete_run();
   end
endmodule // tb_servo_overshoot_gain_switch
`default_nettype wire
